// ---- src/fcd_dma.v ----
// What this block does
// - four channels, each with own trigger and addressing, run concurrently.
// - bursts of 1, 2, 4 or 8 bytes hold the bus once started.
// - block length from count register, 1 byte up to 64KB.
// - repeat count 1..255 blocks per transaction, zero means unlimited.
// - processor bus request wins between bursts; pending bursts wait.
// - channel moves data only after software, peripheral or event request.
// - selecting an absent trigger source has no effect.
// - trigger starts a block; channel disables itself at the end.
// - single-shot mode moves one burst per trigger.
// - with repeat on and single-shot off, next block starts at once without a trigger.
// - one request during a transfer is held pending; later ones dropped.
// - source and destination static, incrementing or decrementing after each access.
// - originals kept; reload after burst, block, transaction or never.
// - fixed priority for chosen channels, round robin with last served lowest.
// - paired channels 0/1 and 2/3 hand over on completion, pairs enabled separately.
// - four-byte buffer; two source bytes read before destination writes, one when only one byte of the burst remains.
// - per-channel error on eeprom write, eeprom read asleep, or disable mid-transfer.
// - controller soft reset clears everything, only while controller disabled.
// - channel soft reset clears that channel, only while channel disabled.
// - while busy only control, flags, temp, trigger, enable and repeat bits change.
// - busy set at transaction start, cleared on disable, complete or error.
// - error and complete flags cleared by writing one.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_dma_map.vh"
module fcd_dma #(
	parameter [15:0] TRIG_PRESENT = 16'hFFFE
) (
	// clock and reset
	input  wire        clk_in,
	input  wire        reset_in,
	// axi4-lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// shared data bus
	input  wire        cpu_bus_req_in,
	output reg         bus_own_out,
	output reg         mem_en_out,
	output reg         mem_we_out,
	output reg  [23:0] mem_addr_out,
	output reg  [7:0]  mem_wdata_out,
	input  wire [7:0]  mem_rdata_in,
	// triggers and eeprom state
	input  wire [15:0] trig_in,
	input  wire        eeprom_sleep_in
);
	localparam S_IDLE = 2'd0;
	localparam S_RD   = 2'd1;
	localparam S_RDC  = 2'd2;
	localparam S_WR   = 2'd3;

	reg        awready_reg, arready_reg, bvalid_reg, rvalid_reg;
	reg [1:0]  bresp_reg, rresp_reg;
	reg [31:0] rdata_reg;
	reg [7:0]  ctl_reg, intf_reg;
	reg [15:0] temp_reg;
	reg [7:0]  chctrl_reg [0:3];
	reg [7:0]  addrc_reg  [0:3];
	reg [7:0]  trig_reg   [0:3];
	reg [15:0] cnt_reg    [0:3];
	reg [7:0]  rep_reg    [0:3];
	reg [23:0] src_reg    [0:3];
	reg [23:0] dst_reg    [0:3];
	reg [23:0] cur_src_reg [0:3];
	reg [23:0] cur_dst_reg [0:3];
	reg [16:0] blk_rem_reg [0:3];
	reg [7:0]  rep_rem_reg [0:3];
	reg [3:0]  busy_reg, pend_reg, act_reg;
	reg [15:0] trig_prev_reg;
	reg [1:0]  state_reg, sel_reg, last_reg, nstage_reg, widx_reg;
	reg [3:0]  bleft_reg;
	reg [7:0]  buf_reg [0:3];

	reg [31:0] rd_val, wr_old, mv;
	reg        rd_ok, wr_ok, mok;
	reg [3:0]  hw_trig;
	reg [7:0]  a;
	integer    i, j, t;

	wire        do_wr  = awready_reg;
	wire [31:0] wv     = fcd_merge(wr_old, s_axi_wdata, s_axi_wstrb);
	wire [2:0]  wgrp   = s_axi_awaddr[7:5];
	wire [2:0]  widx   = s_axi_awaddr[4:2];
	wire [1:0]  wch    = wgrp[1:0] - 2'd1;
	wire        wr_go  = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
	wire [2:0]  pick   = fcd_pick(act_reg, ctl_reg[1:0], last_reg);
	wire [1:0]  s      = sel_reg;
	wire        run_ok = ctl_reg[`FCD_EN_BIT] && chctrl_reg[s][`FCD_EN_BIT];
	wire [16:0] bsize  = {13'h0000, 4'h1 << chctrl_reg[pick[1:0]][1:0]};
	wire [16:0] bfirst = (blk_rem_reg[pick[1:0]] < bsize) ? blk_rem_reg[pick[1:0]] : bsize;
	wire        blast  = (blk_rem_reg[s] == 17'h00001);
	wire        more   = chctrl_reg[s][`FCD_REP_BIT] && ((rep_reg[s] == 8'h00) || (rep_rem_reg[s] > 8'h01));
	wire        tr_end = blast && !more;
	wire [7:0]  ac     = addrc_reg[s];

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = awready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	function [31:0] fcd_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				fcd_merge[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
		end
	endfunction

	// fixed channels first, then round robin from the one after the last served
	function [2:0] fcd_pick;
		input [3:0] req;
		input [1:0] pri;
		input [1:0] last;
		integer k;
		reg [2:0] nfix;
		reg [1:0] c;
		begin
			fcd_pick = 3'h0;
			nfix = (pri == 2'h3) ? 3'h4 : {1'b0, pri};
			c = 2'h0;
			for (k = 3; k >= 0; k = k - 1)
				if (k < nfix && req[k])
					fcd_pick = {1'b1, k[1:0]};
			if (!fcd_pick[2])
				for (k = 4; k >= 1; k = k - 1) begin
					c = last + k[1:0];
					if ({1'b0, c} >= nfix && req[c])
						fcd_pick = {1'b1, c};
				end
		end
	endfunction

	function [23:0] fcd_step;
		input [23:0] ad;
		input [1:0]  dir;
		begin
			if (dir == `FCD_DIR_INC)
				fcd_step = ad + 24'h000001;
			else if (dir == `FCD_DIR_DEC)
				fcd_step = ad - 24'h000001;
			else
				fcd_step = ad;
		end
	endfunction

	function [16:0] fcd_blk;
		input [15:0] c;
		begin
			fcd_blk = (c == 16'h0000) ? 17'h10000 : {1'b0, c};
		end
	endfunction

	function fcd_ee;
		input [23:0] ad;
		begin
			fcd_ee = (ad >= `FCD_EE_LO) && (ad <= `FCD_EE_HI);
		end
	endfunction

	// readback of the read address and of the write address, for byte-lane merging
	always @* begin
		rd_val = 32'h00000000;
		wr_old = 32'h00000000;
		rd_ok  = 1'b0;
		wr_ok  = 1'b0;
		for (j = 0; j < 2; j = j + 1) begin
			a   = (j == 0) ? s_axi_araddr : s_axi_awaddr;
			mv  = 32'h00000000;
			mok = 1'b1;
			if (a[1:0] != 2'h0 || a[7:5] > 3'h4)
				mok = 1'b0;
			else if (a[7:5] == 3'h0) begin
				case (a[4:2])
					`FCD_CTL:  mv = {24'h000000, ctl_reg};
					`FCD_INTF: mv = {24'h000000, intf_reg};
					`FCD_STAT: mv = {24'h000000, busy_reg, pend_reg};
					`FCD_TEMP: mv = {16'h0000, temp_reg};
					default:   mok = 1'b0;
				endcase
			end else begin
				case (a[4:2])
					`FCD_CH_CTRL:  mv = {24'h000000, chctrl_reg[a[6:5] - 2'd1]};
					`FCD_CH_ADDRC: mv = {24'h000000, addrc_reg[a[6:5] - 2'd1]};
					`FCD_CH_TRIG:  mv = {24'h000000, trig_reg[a[6:5] - 2'd1]};
					`FCD_CH_CNT:   mv = {16'h0000, cnt_reg[a[6:5] - 2'd1]};
					`FCD_CH_REP:   mv = {24'h000000, rep_reg[a[6:5] - 2'd1]};
					`FCD_CH_SRC:   mv = {8'h00, cur_src_reg[a[6:5] - 2'd1]};
					`FCD_CH_DST:   mv = {8'h00, cur_dst_reg[a[6:5] - 2'd1]};
					default:       mok = 1'b0;
				endcase
			end
			if (j == 0) begin
				rd_val = mv;
				rd_ok  = mok;
			end else begin
				wr_old = mv;
				wr_ok  = mok;
			end
		end
	end

	// absent trigger modules never fire; own loop variable keeps one driver per variable
	always @* begin
		for (t = 0; t < 4; t = t + 1)
			hw_trig[t] = (trig_reg[t][7:4] == 4'h0) && TRIG_PRESENT[trig_reg[t][3:0]]
				&& trig_in[trig_reg[t][3:0]] && !trig_prev_reg[trig_reg[t][3:0]];
	end

	task ch_clear;
		input integer n;
		begin
			chctrl_reg[n]  <= `FCD_RST_8;
			addrc_reg[n]   <= `FCD_RST_8;
			trig_reg[n]    <= `FCD_RST_8;
			cnt_reg[n]     <= `FCD_RST_16;
			rep_reg[n]     <= `FCD_RST_8;
			src_reg[n]     <= `FCD_RST_24;
			dst_reg[n]     <= `FCD_RST_24;
			cur_src_reg[n] <= `FCD_RST_24;
			cur_dst_reg[n] <= `FCD_RST_24;
			blk_rem_reg[n] <= 17'h10000;
			rep_rem_reg[n] <= `FCD_RST_8;
			busy_reg[n]    <= 1'b0;
			pend_reg[n]    <= 1'b0;
			act_reg[n]     <= 1'b0;
		end
	endtask

	task ch_stop;
		input integer n;
		begin
			chctrl_reg[n][`FCD_EN_BIT] <= 1'b0;
			busy_reg[n] <= 1'b0;
			act_reg[n]  <= 1'b0;
			pend_reg[n] <= 1'b0;
		end
	endtask

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			awready_reg   <= 1'b0;
			arready_reg   <= 1'b0;
			bvalid_reg    <= 1'b0;
			rvalid_reg    <= 1'b0;
			bresp_reg     <= `FCD_RESP_OK;
			rresp_reg     <= `FCD_RESP_OK;
			rdata_reg     <= 32'h00000000;
			ctl_reg       <= `FCD_RST_8;
			intf_reg      <= `FCD_RST_8;
			temp_reg      <= `FCD_RST_16;
			trig_prev_reg <= `FCD_RST_16;
			state_reg     <= S_IDLE;
			sel_reg       <= 2'h0;
			last_reg      <= 2'h3;
			nstage_reg    <= 2'h0;
			widx_reg      <= 2'h0;
			bleft_reg     <= 4'h0;
			bus_own_out   <= 1'b0;
			mem_en_out    <= 1'b0;
			mem_we_out    <= 1'b0;
			mem_addr_out  <= `FCD_RST_24;
			mem_wdata_out <= `FCD_RST_8;
			for (i = 0; i < 4; i = i + 1) begin
				ch_clear(i);
				buf_reg[i] <= `FCD_RST_8;
			end
		end else begin
			trig_prev_reg <= trig_in;
			// axi handshakes: one write and one read at a time
			awready_reg <= wr_go;
			arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
			if (do_wr) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_ok ? `FCD_RESP_OK : `FCD_RESP_ERR;
			end else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (arready_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_ok ? rd_val : 32'h00000000;
				rresp_reg  <= rd_ok ? `FCD_RESP_OK : `FCD_RESP_ERR;
			end else if (s_axi_rready)
				rvalid_reg <= 1'b0;

			// software writes
			if (do_wr && wr_ok && wgrp == 3'h0) begin
				case (widx)
					`FCD_CTL: begin
						ctl_reg <= {wv[7], 3'h0, wv[3:0]};
						if (ctl_reg[`FCD_EN_BIT] && !wv[`FCD_EN_BIT])
							for (i = 0; i < 4; i = i + 1)
								if (busy_reg[i]) begin
									intf_reg[i + 4] <= 1'b1;
									ch_stop(i);
								end
						if (!ctl_reg[`FCD_EN_BIT] && wv[`FCD_RST_BIT]) begin
							ctl_reg  <= `FCD_RST_8;
							intf_reg <= `FCD_RST_8;
							temp_reg <= `FCD_RST_16;
							for (i = 0; i < 4; i = i + 1)
								ch_clear(i);
						end
					end
					`FCD_INTF: intf_reg <= intf_reg & ~wv[7:0];
					`FCD_TEMP: temp_reg <= wv[15:0];
					default: ;
				endcase
			end else if (do_wr && wr_ok) begin
				// busy channels accept only enable, request, repeat and trigger
				case (widx)
					`FCD_CH_CTRL: begin
						chctrl_reg[wch] <= busy_reg[wch] ? {wv[7], 1'b0, wv[5], 2'h0, chctrl_reg[wch][2:0]}
							: {wv[7], 1'b0, wv[5], 2'h0, wv[2:0]};
						if (!chctrl_reg[wch][`FCD_EN_BIT] && wv[`FCD_EN_BIT]) begin
							blk_rem_reg[wch] <= fcd_blk(cnt_reg[wch]);
							rep_rem_reg[wch] <= rep_reg[wch];
							cur_src_reg[wch] <= src_reg[wch];
							cur_dst_reg[wch] <= dst_reg[wch];
						end
						if (chctrl_reg[wch][`FCD_EN_BIT] && !wv[`FCD_EN_BIT]) begin
							ch_stop(wch);
							if (busy_reg[wch])
								intf_reg[wch + 4] <= 1'b1;
						end
						if (wv[`FCD_EN_BIT] && wv[`FCD_TRQ_BIT]) begin
							if (!act_reg[wch]) begin
								act_reg[wch]  <= 1'b1;
								busy_reg[wch] <= 1'b1;
							end else
								pend_reg[wch] <= 1'b1;
						end
						if (!chctrl_reg[wch][`FCD_EN_BIT] && wv[`FCD_RST_BIT])
							ch_clear(wch);
					end
					`FCD_CH_TRIG: trig_reg[wch] <= wv[7:0];
					default: if (!busy_reg[wch]) begin
						case (widx)
							`FCD_CH_ADDRC: addrc_reg[wch] <= wv[7:0];
							`FCD_CH_CNT: begin
								cnt_reg[wch]     <= wv[15:0];
								blk_rem_reg[wch] <= fcd_blk(wv[15:0]);
							end
							`FCD_CH_REP: begin
								rep_reg[wch]     <= wv[7:0];
								rep_rem_reg[wch] <= wv[7:0];
							end
							`FCD_CH_SRC: begin
								src_reg[wch]     <= wv[23:0];
								cur_src_reg[wch] <= wv[23:0];
							end
							`FCD_CH_DST: begin
								dst_reg[wch]     <= wv[23:0];
								cur_dst_reg[wch] <= wv[23:0];
							end
							default: ;
						endcase
					end
				endcase
			end

			// hardware requests; a second one while pending is dropped
			for (i = 0; i < 4; i = i + 1)
				if (hw_trig[i] && chctrl_reg[i][`FCD_EN_BIT]) begin
					if (!act_reg[i]) begin
						act_reg[i]  <= 1'b1;
						busy_reg[i] <= 1'b1;
					end else
						pend_reg[i] <= 1'b1;
				end

			// engine: one burst at a time on the shared bus
			case (state_reg)
				S_IDLE: begin
					mem_en_out  <= 1'b0;
					bus_own_out <= 1'b0;
					if (ctl_reg[`FCD_EN_BIT] && !cpu_bus_req_in && pick[2]) begin
						sel_reg     <= pick[1:0];
						last_reg    <= pick[1:0];
						bleft_reg   <= bfirst[3:0];
						nstage_reg  <= 2'h0;
						bus_own_out <= 1'b1;
						state_reg   <= S_RD;
					end
				end
				S_RD: begin
					if (!run_ok) begin
						state_reg  <= S_IDLE;
						mem_en_out <= 1'b0;
					end else if (fcd_ee(cur_src_reg[s]) && eeprom_sleep_in) begin
						intf_reg[s + 4] <= 1'b1;
						ch_stop(s);
						state_reg  <= S_IDLE;
						mem_en_out <= 1'b0;
					end else begin
						mem_en_out     <= 1'b1;
						mem_we_out     <= 1'b0;
						mem_addr_out   <= cur_src_reg[s];
						cur_src_reg[s] <= fcd_step(cur_src_reg[s], ac[5:4]);
						state_reg      <= S_RDC;
					end
				end
				S_RDC: begin
					mem_en_out          <= 1'b0;
					buf_reg[nstage_reg] <= mem_rdata_in;
					nstage_reg          <= nstage_reg + 2'h1;
					bleft_reg           <= bleft_reg - 4'h1;
					widx_reg            <= 2'h0;
					// at most two bytes staged before writing bounds bus hold per source timing
					state_reg <= (nstage_reg == 2'h1 || bleft_reg == 4'h1) ? S_WR : S_RD;
				end
				default: begin
					if (!run_ok) begin
						state_reg  <= S_IDLE;
						mem_en_out <= 1'b0;
					end else if (fcd_ee(cur_dst_reg[s])) begin
						intf_reg[s + 4] <= 1'b1;
						ch_stop(s);
						state_reg  <= S_IDLE;
						mem_en_out <= 1'b0;
					end else begin
						mem_en_out     <= 1'b1;
						mem_we_out     <= 1'b1;
						mem_addr_out   <= cur_dst_reg[s];
						mem_wdata_out  <= buf_reg[widx_reg];
						cur_dst_reg[s] <= fcd_step(cur_dst_reg[s], ac[1:0]);
						blk_rem_reg[s] <= blk_rem_reg[s] - 17'h00001;
						widx_reg       <= widx_reg + 2'h1;
						if (widx_reg + 2'h1 != nstage_reg)
							state_reg <= S_WR;
						else if (bleft_reg != 4'h0) begin
							nstage_reg <= 2'h0;
							state_reg  <= S_RD;
						end else begin
							nstage_reg <= 2'h0;
							state_reg  <= S_IDLE;
							if (ac[7:6] == `FCD_RL_BURST || (blast && ac[7:6] == `FCD_RL_BLOCK)
								|| (tr_end && ac[7:6] == `FCD_RL_TRANS))
								cur_src_reg[s] <= src_reg[s];
							if (ac[3:2] == `FCD_RL_BURST || (blast && ac[3:2] == `FCD_RL_BLOCK)
								|| (tr_end && ac[3:2] == `FCD_RL_TRANS))
								cur_dst_reg[s] <= dst_reg[s];
							if (tr_end) begin
								ch_stop(s);
								intf_reg[s] <= 1'b1;
								if (ctl_reg[2 + s[1]])
									chctrl_reg[s ^ 2'h1][`FCD_EN_BIT] <= 1'b1;
							end else if (blast) begin
								blk_rem_reg[s] <= fcd_blk(cnt_reg[s]);
								if (rep_reg[s] != 8'h00)
									rep_rem_reg[s] <= rep_rem_reg[s] - 8'h01;
								else
									intf_reg[s] <= 1'b1;
								if (chctrl_reg[s][`FCD_SGL_BIT]) begin
									act_reg[s]  <= pend_reg[s] | hw_trig[s];
									pend_reg[s] <= 1'b0;
								end
							end else if (chctrl_reg[s][`FCD_SGL_BIT]) begin
								act_reg[s]  <= pend_reg[s] | hw_trig[s];
								pend_reg[s] <= 1'b0;
							end
						end
					end
				end
			endcase
		end
	end
endmodule // fcd_dma
`default_nettype wire

// ---- src/fcd_dma_map.vh ----
`ifndef FCD_DMA_MAP_VH
`define FCD_DMA_MAP_VH
// register index inside a 32-byte group, byte address = group*32 + index*4
`define FCD_CTL          3'h0
`define FCD_INTF         3'h1
`define FCD_STAT         3'h2
`define FCD_TEMP         3'h3
`define FCD_CH_CTRL      3'h0
`define FCD_CH_ADDRC     3'h1
`define FCD_CH_TRIG      3'h2
`define FCD_CH_CNT       3'h3
`define FCD_CH_REP       3'h4
`define FCD_CH_SRC       3'h5
`define FCD_CH_DST       3'h6
// control bit positions
`define FCD_EN_BIT       7
`define FCD_RST_BIT      6
`define FCD_REP_BIT      5
`define FCD_TRQ_BIT      4
`define FCD_SGL_BIT      2
// address step and reload codes
`define FCD_DIR_INC      2'h1
`define FCD_DIR_DEC      2'h2
`define FCD_RL_BURST     2'h1
`define FCD_RL_BLOCK     2'h2
`define FCD_RL_TRANS     2'h3
// memory-mapped eeprom window
`define FCD_EE_LO        24'h001000
`define FCD_EE_HI        24'h001FFF
// reset values and bus answers
`define FCD_RST_8        8'h00
`define FCD_RST_16       16'h0000
`define FCD_RST_24       24'h000000
`define FCD_RESP_OK      2'h0
`define FCD_RESP_ERR     2'h2
`endif

// ---- tb/fcd_dma_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_monitor (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        reset_in,
	// register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// data bus
	input wire logic        cpu_bus_req_in,
	input wire logic        bus_own_out,
	input wire logic        mem_en_out,
	input wire logic        mem_we_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire rd_acc = mem_en_out && !mem_we_out;
	wire wr_acc = mem_en_out && mem_we_out;
	a_cpu_first: assert property ($rose(bus_own_out) |-> !$past(cpu_bus_req_in))
		else $error("burst taken against cpu request");
	a_access_owned: assert property (mem_en_out |-> bus_own_out)
		else $error("access without the bus");
	a_burst_bounded: assert property ($rose(bus_own_out) |-> ##[1:30] !bus_own_out)
		else $error("bus held too long");
	a_read_first: assert property ($rose(bus_own_out) |=> rd_acc or (!mem_en_out ##1 !bus_own_out))
		else $error("burst not opened by a read");
	a_read_gap: assert property (rd_acc |=> !mem_en_out)
		else $error("no capture slot after read");
	a_write_after_read: assert property (wr_acc && !$past(wr_acc) |-> $past(rd_acc, 2))
		else $error("write not preceded by read");
	a_write_answer: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	c_burst: cover property ($rose(bus_own_out));
	c_pair_write: cover property (wr_acc ##1 wr_acc);
	c_cpu_wait: cover property (cpu_bus_req_in && !bus_own_out);
endmodule // fcd_dma_monitor
bind fcd_dma fcd_dma_monitor u_fcd_dma_monitor (.clk_in, .reset_in, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.cpu_bus_req_in, .bus_own_out, .mem_en_out, .mem_we_out);
`default_nettype wire

// ---- tb/fcd_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcd_mem_model (
	// clock
	input wire logic       clk_in,
	// engine side
	input wire logic       mem_en_in,
	input wire logic       mem_we_in,
	input wire logic [23:0] mem_addr_in,
	input wire logic [7:0] mem_wdata_in,
	output logic [7:0]     mem_rdata_out,
	// processor side
	input wire logic       cpu_want_in,
	output logic           cpu_bus_req_out
);
	logic [7:0] mem [0:255];
	logic [7:0] hold_reg = 8'h5A;
	logic       hold_v_reg = 1'b0;
	wire        rd_now = mem_en_in && !mem_we_in;
	// valid in strobe and capture slot; otherwise inverted so stale data never matches
	assign mem_rdata_out = rd_now ? mem[mem_addr_in[7:0]] : (hold_v_reg ? hold_reg : ~hold_reg);
	initial cpu_bus_req_out = 1'b0;
	always @(posedge clk_in) begin
		hold_v_reg <= rd_now;
		if (rd_now)
			hold_reg <= mem[mem_addr_in[7:0]];
		if (mem_en_in && mem_we_in)
			mem[mem_addr_in[7:0]] <= mem_wdata_in;
		cpu_bus_req_out <= cpu_want_in;
	end
	task poke(input logic [7:0] a, input logic [7:0] v);
		mem[a] = v;
	endtask
endmodule // fcd_mem_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_in = 1'b0, reset_in = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire bus_own_out, mem_en_out, mem_we_out, cpu_bus_req_in;
	wire [23:0] mem_addr_out;
	wire [7:0] mem_wdata_out, mem_rdata_in;
	logic [15:0] trig_in = 16'h0;
	logic eeprom_sleep_in = 0, cpu_want = 0, stall = 0, score = 1;
	logic [31:0] rnd = 32'd66473, d;
	logic [7:0] img [0:255];
	logic [31:0] mem_q[$];
	logic [33:0] rd_q[$];
	int error_cnt = 0, checks = 0, cyc = 0;

	fcd_dma #(.TRIG_PRESENT(16'h7FFF)) u_fcd_dma (.clk_in, .reset_in, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_bus_req_in, .bus_own_out, .mem_en_out,
		.mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_rdata_in, .trig_in, .eeprom_sleep_in);
	fcd_mem_model u_fcd_mem_model (.clk_in, .mem_en_in(mem_en_out), .mem_we_in(mem_we_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in),
		.cpu_want_in(cpu_want), .cpu_bus_req_out(cpu_bus_req_in));

	always #10 clk_in = ~clk_in;
	function logic [31:0] lfsr(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'hA3000000 : 32'h0);
	endfunction
	function logic [23:0] step(input logic [23:0] a, input logic [1:0] m);
		return m == 2'h1 ? a + 24'h1 : (m == 2'h2 ? a - 24'h1 : a);
	endfunction
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [33:0] s, input logic [33:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// random processor traffic keeps the arbiter busy
	always @(posedge clk_in) begin
		rnd <= lfsr(rnd);
		cpu_want <= stall && rnd[1:0] == 2'h0;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			wrap_up();
		end
	end
	always @(posedge clk_in) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready && rd_q.size() > 0)
			chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
		if (mem_en_out === 1'b1 && mem_we_out === 1'b1 && score) begin
			if (mem_q.size() > 0)
				chk({2'h0, mem_addr_out, mem_wdata_out}, {2'h0, mem_q.pop_front()});
			else
				chk(34'h1, 34'h0);
		end
	end
	task axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clk_in); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clk_in); while (s_axi_bvalid !== 1'b1);
		chk({32'h0, s_axi_bresp}, 34'h0);
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, input logic [33:0] e, input bit sc);
		@(posedge clk_in);
		if (sc)
			rd_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_in); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_in); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
	task wait_idle(input int ch);
		repeat (2) @(posedge clk_in);
		do axi_rd(8'h08, 34'h0, 0); while (d[4 + ch] !== 1'b0);
	endtask
	task pulse(input int k);
		@(posedge clk_in);
		trig_in <= 16'(1 << k);
		@(posedge clk_in);
		trig_in <= 16'h0;
	endtask
	// expected destination writes from the channel settings
	task plan(input logic [1:0] bl, input logic [7:0] ac, input int cnt, input int nblk,
		input logic [23:0] sa0, input logic [23:0] da0);
		logic [23:0] sa, da;
		sa = sa0;
		da = da0;
		for (int b = 0; b < nblk; b++) begin
			for (int i = 1; i <= cnt; i++) begin
				mem_q.push_back({da, img[sa[7:0]]});
				sa = step(sa, ac[5:4]);
				da = step(da, ac[1:0]);
				if (i % (1 << bl) == 0 && ac[7:6] == 2'h1)
					sa = sa0;
				if (i % (1 << bl) == 0 && ac[3:2] == 2'h1)
					da = da0;
			end
			if (ac[7:6] == 2'h2)
				sa = sa0;
			if (ac[3:2] == 2'h2)
				da = da0;
		end
	endtask
	task cfg(input int ch, input logic [7:0] ctl, input logic [7:0] ac, input logic [7:0] trg,
		input logic [15:0] cnt, input logic [7:0] rep, input logic [23:0] sa, input logic [23:0] da);
		logic [7:0] b;
		b = 8'(32 * (ch + 1));
		axi_wr(b + 8'h04, {24'h0, ac});
		axi_wr(b + 8'h08, {24'h0, trg});
		axi_wr(b + 8'h0C, {16'h0, cnt});
		axi_wr(b + 8'h10, {24'h0, rep});
		axi_wr(b + 8'h14, {8'h0, sa});
		axi_wr(b + 8'h18, {8'h0, da});
		axi_wr(b, {24'h0, ctl});
	endtask
	task done(input int ch, input logic [7:0] ctl);
		chk({2'h0, 32'(mem_q.size())}, 34'h0);
		axi_rd(8'h04, {2'h0, 32'(1 << ch)}, 1);
		axi_wr(8'h04, 32'(1 << ch));
		axi_rd(8'h04, 34'h0, 1);
		axi_rd(8'(32 * (ch + 1)), {26'h0, ctl}, 1);
	endtask
	initial begin
		for (int i = 0; i < 256; i++) begin
			rnd = lfsr(rnd);
			img[i] = rnd[7:0];
			u_fcd_mem_model.poke(8'(i), rnd[7:0]);
		end
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 4; i++)
			axi_rd(8'(4 * i), 34'h0, 1);
		axi_rd(8'h1C, {2'h2, 32'h0}, 1);
		$display("reset values done");
		axi_wr(8'h00, 32'h80);
		stall = 1;
		for (int b = 0; b < 4; b++) begin
			plan(2'(b), 8'h10 | 8'(b % 3), 2 << b, 1, 24'(16 * b), 24'h90);
			cfg(0, 8'h90 | 8'(b), 8'h10 | 8'(b % 3), 8'h0, 16'(2 << b), 8'h0, 24'(16 * b), 24'h90);
			wait_idle(0);
			done(0, 8'(b));
		end
		$display("burst sizes and directions done");
		plan(2'h0, 8'h91, 2, 2, 24'h40, 24'hA0);
		cfg(2, 8'hB0, 8'h91, 8'h0, 16'h2, 8'h2, 24'h40, 24'hA0);
		wait_idle(2);
		done(2, 8'h20);
		$display("repeat and reload done");
		cfg(3, 8'h84, 8'h11, 8'h0F, 16'h2, 8'h0, 24'h50, 24'hB0);
		pulse(15);
		repeat (30) @(posedge clk_in);
		axi_rd(8'h08, 34'h0, 1);
		plan(2'h0, 8'h11, 2, 1, 24'h50, 24'hB0);
		axi_wr(8'h88, 32'h3);
		pulse(3);
		repeat (40) @(posedge clk_in);
		chk({2'h0, 32'(mem_q.size())}, 34'h1);
		axi_rd(8'h08, 34'h0, 0);
		chk({33'h0, d[7]}, 34'h1);
		axi_wr(8'h8C, 32'h55);
		pulse(3);
		wait_idle(3);
		axi_rd(8'h8C, 34'h2, 1);
		done(3, 8'h04);
		$display("single shot and protection done");
		score = 0;
		eeprom_sleep_in <= 1'b1;
		cfg(1, 8'h90, 8'h11, 8'h0, 16'h2, 8'h0, 24'h001000, 24'hC0);
		wait_idle(1);
		eeprom_sleep_in <= 1'b0;
		score = 1;
		axi_rd(8'h04, 34'h20, 1);
		axi_wr(8'h04, 32'h20);
		$display("eeprom error done");
		axi_wr(8'h00, 32'h84);
		cfg(1, 8'h00, 8'h11, 8'h0, 16'h1, 8'h0, 24'h60, 24'hD0);
		plan(2'h0, 8'h11, 1, 1, 24'h60, 24'hD0);
		cfg(0, 8'h90, 8'h11, 8'h0, 16'h1, 8'h0, 24'h60, 24'hD0);
		wait_idle(0);
		axi_rd(8'h40, 34'h80, 1);
		axi_wr(8'h04, 32'h1);
		$display("double buffer done");
		axi_wr(8'h20, 32'h40);
		axi_rd(8'h2C, 34'h0, 1);
		axi_wr(8'h00, 32'h0);
		axi_wr(8'h00, 32'h40);
		axi_rd(8'h6C, 34'h0, 1);
		$display("soft resets done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
